// File: rtl/pcs_pkg.sv
// Package: constants and types for the program counter sequencer
package pcs_pkg;
	localparam int PCS_PC_W_DEF = 11;
	localparam int PCS_PAGE_LO_BIT = 9;
	localparam int PCS_CALL_FORCE_BIT = 8;
	localparam int PCS_STATUS_PA_LSB = 5;
	localparam int PCS_STATUS_PA_MSB = 6;
	localparam int PCS_STACK_DEPTH = 2;
	localparam logic [1:0] PCS_PAGE_RST = 2'h0;
	localparam logic [7:0] PCS_WREG_RST = 8'h00;
	localparam logic [2:0] PCS_PCL_BIT_MAX = 3'h7;
	// Operation requested by the decoder for this instruction cycle
	typedef enum logic [2:0] {
		PCS_OP_SEQ = 3'h0,
		PCS_OP_JUMP = 3'h1,
		PCS_OP_CALL = 3'h3,
		PCS_OP_RET = 3'h2,
		PCS_OP_PCL_MOVE = 3'h6,
		PCS_OP_PCL_ADD = 3'h7,
		PCS_OP_PCL_BSET = 3'h5,
		PCS_OP_PA_WRITE = 3'h4
	} pcs_op_e;
endpackage

// File: rtl/pcs_return_stack.sv
// Two-entry hardware return stack
`timescale 1ns/100ps
`default_nettype none
module pcs_return_stack import pcs_pkg::*; #(
	parameter int PC_W = PCS_PC_W_DEF
) (
	input wire logic i_clk_sys,
	input wire logic i_reset_n,
	input wire logic i_ce,
	pcs_stack_if.stk stk
);
	typedef struct packed {
		logic [PCS_STACK_DEPTH-1:0][PC_W-1:0] ent;
	} pcs_stk_s;
	pcs_stk_s st_q;
	pcs_stk_s st_d;
	always_comb begin
		st_d = st_q;
		if (stk.push) begin
			// Entry one slides down, oldest entry is lost
			st_d.ent[1] = st_q.ent[0]; // see RULE12
			st_d.ent[0] = stk.push_addr; // see RULE12
		end else if (stk.pop) begin
			// Entry two is copied up and also kept
			st_d.ent[0] = st_q.ent[1]; // see RULE13
		end
	end
	always_ff @(posedge i_clk_sys) begin
		if (!i_reset_n) begin
			st_q <= '0;
		end else if (i_ce) begin
			st_q <= st_d;
		end
	end
	assign stk.top = st_q.ent[0];
endmodule
`default_nettype wire

// File: rtl/pcs_stack_if.sv
// Interface: push/pop handshake between sequencer and return stack
`timescale 1ns/100ps
`default_nettype none
interface pcs_stack_if #(parameter int PC_W = 11);
	logic push;
	logic pop;
	logic [PC_W-1:0] push_addr;
	logic [PC_W-1:0] top;
	modport seq (output push, output pop, output push_addr, input top);
	modport stk (input push, input pop, input push_addr, output top);
endinterface
`default_nettype wire

// File: rtl/pcs_top.sv
// Program counter sequencer with paging and return stack
// Behaviour
// RULE1: Counter increments each cycle unless loaded.
// RULE2: Absolute jump loads counter bits 8:0.
// RULE3: Counter low byte readable and writable.
// RULE4: Page bits feed counter bits 9,10.
// RULE5: Call and low-byte writes clear bit 8.
// RULE6: Move/add/bit-set to low byte jumps.
// RULE7: Increment crosses pages; page bits unchanged.
// RULE8: Software updates page bits after crossing.
// RULE9: Reset sets counter to all ones.
// RULE10: Reset clears the page preselect bits.
// RULE11: Two-entry stack, full counter width.
// RULE12: Call pushes entry one down, stores pc+1.
// RULE13: Return loads top, copies entry two up.
// RULE14: Return loads working register with literal.
// RULE15: Status bits 6:5 select 512-word page.
// RULE16: Widths 9,10,11; excess page bits ignored.
`timescale 1ns/100ps
`default_nettype none
module pcs_top import pcs_pkg::*; #(
	parameter int PC_W = PCS_PC_W_DEF
) (
	input wire logic i_clk_sys,
	input wire logic i_reset_n,
	input wire logic i_ce,
	input wire pcs_op_e i_op,
	input wire logic [8:0] i_imm,
	input wire logic [7:0] i_wreg,
	input wire logic [2:0] i_bit_sel,
	input wire logic [1:0] i_page_wdata,
	output logic [PC_W-1:0] o_pc,
	output logic [7:0] o_pc_low_byte_reg,
	output logic [1:0] o_page_preselect,
	output logic [7:0] o_wreg,
	output logic o_wreg_load
);
	generate
		if (PC_W < 9 || PC_W > 11) begin : g_bad_width
			$error("PC_W must be 9, 10 or 11"); // see RULE16
		end
		if (PCS_STATUS_PA_MSB - PCS_STATUS_PA_LSB != 1) begin : g_bad_page_field
			$error("page preselect field must be two bits wide"); // see RULE15
		end
		if (PCS_STACK_DEPTH != 2) begin : g_bad_depth
			$error("return stack must hold two entries"); // see RULE11
		end
		if (PCS_CALL_FORCE_BIT != PCS_PAGE_LO_BIT - 1) begin : g_bad_force_bit
			$error("forced-low bit must sit just below the page bits"); // see RULE5
		end
	endgenerate

	// Sequencer state apart from the return stack, registered once per enabled cycle
	typedef struct packed {
		logic [PC_W-1:0] pc;
		logic [1:0] page;
		logic [7:0] wreg;
		logic wreg_load;
	} pcs_top_s;

	pcs_top_s st_q;
	pcs_top_s st_d;
	pcs_stack_if #(.PC_W(PC_W)) stk_if ();

	logic [PC_W-1:0] pc_inc;
	wire logic [PC_W-1:0] page_base;
	logic [7:0] low_sum;
	wire logic [7:0] low_bset;
	logic [7:0] short_low;
	logic [PC_W-1:0] short_target;

	// Page bits beyond the configured width are dropped
	assign page_base[PCS_PAGE_LO_BIT-1:0] = '0;
	generate
		for (genvar gb = PCS_PAGE_LO_BIT; gb < PC_W; gb++) begin : g_page_bit
			assign page_base[gb] = st_q.page[gb-PCS_PAGE_LO_BIT]; // see RULE4, RULE15, RULE16
		end
	endgenerate

	always_comb begin
		pc_inc = st_q.pc + PC_W'(1); // see RULE7
		// Add works on the low byte of the current counter value
		low_sum = st_q.pc[7:0] + i_wreg; // see RULE3
	end

	// Bit-set of the low byte, one gate per bit
	generate
		for (genvar gs = 0; gs <= int'(PCS_PCL_BIT_MAX); gs++) begin : g_bset_bit
			assign low_bset[gs] = st_q.pc[gs] | (i_bit_sel == 3'(gs)); // see RULE3, RULE6
		end
	endgenerate

	// Low byte of every short load: call target or new low-byte value
	always_comb begin
		case (i_op)
			PCS_OP_CALL: begin
				short_low = i_imm[7:0]; // see RULE5
			end

			PCS_OP_PCL_MOVE: begin
				short_low = i_wreg; // see RULE6
			end

			PCS_OP_PCL_ADD: begin
				short_low = low_sum; // see RULE6
			end

			PCS_OP_PCL_BSET: begin
				short_low = low_bset; // see RULE6
			end

			default: begin
				short_low = i_imm[7:0];
			end
		endcase
	end

	// Calls and low-byte writes reach only the first half of the selected page
	always_comb begin
		short_target = page_base;
		short_target[PCS_CALL_FORCE_BIT] = 1'b0; // see RULE5
		short_target[7:0] = short_low; // see RULE5
	end

	always_comb begin
		st_d = st_q;
		st_d.pc = pc_inc; // see RULE1, RULE7
		st_d.wreg_load = 1'b0;
		stk_if.push = 1'b0;
		stk_if.pop = 1'b0;
		stk_if.push_addr = pc_inc; // see RULE12

		// Every load other than the increment is chosen by the decoded operation
		case (i_op)
			PCS_OP_SEQ: begin
				// Increment only; a page crossing leaves the page bits alone
			end

			PCS_OP_JUMP: begin
				st_d.pc = page_base; // see RULE4
				st_d.pc[8:0] = i_imm; // see RULE2
			end

			PCS_OP_CALL: begin
				stk_if.push = 1'b1; // see RULE12
				st_d.pc = short_target; // see RULE4, RULE5
			end

			PCS_OP_RET: begin
				// Return addresses hold their page, so no page bits are applied
				stk_if.pop = 1'b1;
				st_d.pc = stk_if.top; // see RULE13, RULE11
				st_d.wreg = i_imm[7:0]; // see RULE14
				st_d.wreg_load = 1'b1; // see RULE14
			end

			PCS_OP_PCL_MOVE: begin
				st_d.pc = short_target; // see RULE6, RULE5
			end

			PCS_OP_PCL_ADD: begin
				st_d.pc = short_target; // see RULE6, RULE5
			end

			PCS_OP_PCL_BSET: begin
				st_d.pc = short_target; // see RULE6, RULE5
			end

			PCS_OP_PA_WRITE: begin
				// Software steers later jumps after a page crossing
				st_d.page = i_page_wdata; // see RULE8
			end

			default: begin
			end
		endcase
	end

	always_ff @(posedge i_clk_sys) begin
		if (!i_reset_n) begin
			st_q.pc <= '1; // see RULE9
			st_q.page <= PCS_PAGE_RST; // see RULE10
			st_q.wreg <= PCS_WREG_RST;
			st_q.wreg_load <= 1'b0;
		end else if (i_ce) begin
			st_q <= st_d;
		end
	end

	// Stack shares the clock enable, so a frozen core keeps its return addresses
	pcs_return_stack #(.PC_W(PC_W)) u_stack (
		.i_clk_sys(i_clk_sys),
		.i_reset_n(i_reset_n),
		.i_ce(i_ce),
		.stk(stk_if.stk)
	);

	// Outputs are taken straight from the state register
	assign o_pc = st_q.pc;
	assign o_pc_low_byte_reg = st_q.pc[7:0]; // see RULE3
	assign o_page_preselect = st_q.page;
	assign o_wreg = st_q.wreg;
	assign o_wreg_load = st_q.wreg_load;
endmodule
`default_nettype wire

// File: sim/pcs_dec_model.sv
// Decoder model: one instruction per cycle
`timescale 1ns/100ps
`default_nettype none
module pcs_dec_model import pcs_pkg::*; (
	input wire logic i_clk_sys,
	output var pcs_op_e o_op,
	output logic [8:0] o_imm
);
	initial begin
		o_op = PCS_OP_SEQ;
		o_imm = 9'h0;
	end
	task automatic issue(pcs_op_e op, logic [8:0] imm);
		@(posedge i_clk_sys);
		#1;
		o_op = op;
		o_imm = imm;
	endtask
endmodule
`default_nettype wire

// File: sim/pcs_properties.sv
// Checker for the program counter sequencer
`timescale 1ns/100ps
`default_nettype none
module pcs_chk import pcs_pkg::*; #(parameter int PC_W = PCS_PC_W_DEF) (
	input wire logic i_clk_sys,
	input wire logic i_reset_n,
	input wire logic i_ce,
	input wire pcs_op_e i_op,
	input wire logic [8:0] i_imm,
	input wire logic [7:0] i_wreg,
	input wire logic [1:0] i_page_wdata,
	input wire logic [PC_W-1:0] o_pc,
	input wire logic [1:0] o_page_preselect,
	input wire logic [7:0] o_wreg,
	input wire logic o_wreg_load
);
	default clocking @(posedge i_clk_sys); endclocking
	default disable iff (!i_reset_n);
	logic [7:0] go;
	assign go = i_ce ? 8'h1 << i_op : 8'h0;
	property p_seq; go[0] |=> o_pc == $past(o_pc) + 1'b1; endproperty
	a_seq: assert property (p_seq) else $error("seq");
	property p_pg; go[0] |=> $stable(o_page_preselect); endproperty
	a_pg: assert property (p_pg) else $error("pg");
	property p_jmp; go[1] |=> o_pc == PC_W'({$past(o_page_preselect), $past(i_imm)}); endproperty
	a_jmp: assert property (p_jmp) else $error("jmp");
	property p_call; go[3] |=> o_pc == PC_W'({$past(o_page_preselect), 1'b0, $past(i_imm[7:0])}); endproperty
	a_call: assert property (p_call) else $error("call");
	property p_ret; go[2] |=> o_wreg == $past(i_imm[7:0]); endproperty
	a_ret: assert property (p_ret) else $error("ret");
	property p_cr; go[3] ##1 go[2] |=> o_pc == $past(o_pc, 2) + 1'b1; endproperty
	a_cr: assert property (p_cr) else $error("cr");
	property p_rr; go[3] ##1 go[3] ##1 go[2] ##1 go[2] |=> o_pc == $past(o_pc, 4) + 1'b1; endproperty
	a_rr: assert property (p_rr) else $error("rr");
	property p_rst; disable iff (1'b0) !i_reset_n |=> &o_pc && !o_page_preselect; endproperty
	a_rst: assert property (p_rst) else $error("rst");
	property p_pcl; go[6] |=> o_pc == PC_W'({$past(o_page_preselect), 1'b0, $past(i_wreg)}); endproperty
	a_pcl: assert property (p_pcl) else $error("pcl");
	property p_pgw; go[4] |=> o_page_preselect == $past(i_page_wdata) && o_pc == $past(o_pc) + 1'b1; endproperty
	a_pgw: assert property (p_pgw) else $error("pgw");
	property p_wld; i_ce |=> o_wreg_load == $past(go[2]); endproperty
	a_wld: assert property (p_wld) else $error("wld");
	property p_hold; !i_ce |=> $stable(o_pc) && $stable(o_page_preselect)
		&& $stable(o_wreg) && $stable(o_wreg_load); endproperty
	a_hold: assert property (p_hold) else $error("hold");
	c_hold: cover property (!i_ce);
	c_cc: cover property (go[3] ##1 go[3]);
	c_rr: cover property (go[2] ##1 go[2]);
	c_x: cover property (go[0] && o_pc[8:0] == 9'h1ff);
endmodule
bind pcs_top pcs_chk #(.PC_W(PC_W)) u_chk (.i_clk_sys(i_clk_sys), .i_reset_n(i_reset_n), .i_ce(i_ce),
	.i_op(i_op), .i_imm(i_imm), .i_wreg(i_wreg), .i_page_wdata(i_page_wdata), .o_pc(o_pc),
	.o_page_preselect(o_page_preselect), .o_wreg(o_wreg), .o_wreg_load(o_wreg_load));
`default_nettype wire

// File: sim/pcs_top_tb_top.sv
// Bench for the program counter sequencer
`timescale 1ns/100ps
`default_nettype none
module pcs_top_tb_top import pcs_pkg::*;;
	logic clk, rst_n, ce = 1'b1, wl;
	pcs_op_e op;
	logic [8:0] imm;
	logic [7:0] w = 8'h0, lo, wr;
	logic [2:0] b = 3'h0;
	logic [1:0] p = 2'h0, pa;
	logic [10:0] pc;
	int errors = 0, n_compared = 0;
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	pcs_dec_model u_dec (.i_clk_sys(clk), .o_op(op), .o_imm(imm));
	pcs_top #(.PC_W(11)) dut_u (.i_clk_sys(clk), .i_reset_n(rst_n), .i_ce(ce), .i_op(op), .i_imm(imm),
		.i_wreg(w), .i_bit_sel(b), .i_page_wdata(p), .o_pc(pc), .o_pc_low_byte_reg(lo),
		.o_page_preselect(pa), .o_wreg(wr), .o_wreg_load(wl));
	task automatic chk(string nm, logic [10:0] s, logic [10:0] e);
		n_compared++;
		if (s !== e) begin
			errors++;
			$display("unexpected %s exp %h seen %h", nm, e, s);
		end
	endtask
	task automatic end_of_test();
		$display("compared %0d errors %0d", n_compared, errors);
		if (errors == 0 && n_compared > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	task automatic t_page();
		chk("pc", pc, 11'h7ff);
		chk("pa", pa, 11'h0);
		u_dec.issue(PCS_OP_PA_WRITE, 9'h0);
		p = 2'h1;
		chk("pc", pc, 11'h0);
		u_dec.issue(PCS_OP_JUMP, 9'h1ff);
		u_dec.issue(PCS_OP_SEQ, 9'h0);
		u_dec.issue(PCS_OP_JUMP, 9'h5);
		chk("pc", pc, 11'h400);
		u_dec.issue(PCS_OP_SEQ, 9'h0);
		chk("pc", pc, 11'h205);
		$display("page done");
	endtask
	task automatic t_call();
		u_dec.issue(PCS_OP_CALL, 9'h10);
		u_dec.issue(PCS_OP_CALL, 9'h20);
		chk("pc", pc, 11'h210);
		u_dec.issue(PCS_OP_RET, 9'h55);
		u_dec.issue(PCS_OP_RET, 9'h66);
		chk("pc", pc, 11'h211);
		chk("w", wr, 11'h55);
		chk("wl", wl, 11'h1);
		u_dec.issue(PCS_OP_RET, 9'h77);
		u_dec.issue(PCS_OP_PCL_MOVE, 9'h0);
		w = 8'h80;
		chk("pc", pc, 11'h207);
		u_dec.issue(PCS_OP_PCL_ADD, 9'h0);
		w = 8'h03;
		chk("wl", wl, 11'h0);
		u_dec.issue(PCS_OP_PCL_BSET, 9'h0);
		b = 3'h2;
		u_dec.issue(PCS_OP_SEQ, 9'h0);
		chk("pc", pc, 11'h287);
		chk("lo", lo, 11'h87);
		$display("call done");
	endtask
	task automatic t_hold();
		u_dec.issue(PCS_OP_JUMP, 9'h33);
		ce = 1'b0;
		u_dec.issue(PCS_OP_SEQ, 9'h0);
		ce = 1'b1;
		chk("pc", pc, 11'h288);
		u_dec.issue(PCS_OP_CALL, 9'h40);
		rst_n = 1'b0;
		u_dec.issue(PCS_OP_SEQ, 9'h0);
		rst_n = 1'b1;
		chk("pc", pc, 11'h7ff);
		chk("pa", pa, 11'h0);
		chk("w", wr, 11'h0);
		u_dec.issue(PCS_OP_JUMP, 9'h12);
		u_dec.issue(PCS_OP_SEQ, 9'h0);
		chk("pc", pc, 11'h012);
		$display("hold done");
	endtask
	initial begin
		rst_n = 1'b0;
		repeat (2) @(posedge clk);
		#1;
		rst_n = 1'b1;
		t_page();
		t_call();
		t_hold();
		end_of_test();
	end
	initial begin
		#100000;
		errors++;
		end_of_test();
	end
endmodule
`default_nettype wire
